// [common/scaling_pkg.sv]
/*
  Constants, register map and carrier types for the output scaling datapath.
  Assumes one clock domain; demodulator results arrive already on that clock.
*/
package scaling_pkg;
  localparam int VAL_W = 32;
  localparam int FRAC_BITS = 22;
  localparam int CODE_SHIFT = 7;
  localparam int DIV_STEPS_DEF = 64;
  // Full scale (10 V) as a Q22 fraction of sensitivity
  localparam logic signed [63:0] FS_Q = 64'sh0000_0000_0040_0000;
  localparam logic signed [63:0] F_LIMIT = 64'sh0000_0100_0000_0000;
  localparam logic signed [15:0] CODE_MAX = 16'sh7fff;
  localparam logic signed [15:0] CODE_MIN = -16'sh7fff;
  // Offsets held in hundredths of a percent, up to 999 percent
  localparam logic signed [17:0] PCT_MAX = 18'sh1863c;
  localparam logic signed [63:0] PCT_SCALE = 64'sh0000_0000_0000_2710;
  // Phase in millidegrees, 180 degrees gives full-scale code
  localparam logic signed [63:0] PHASE_FS_MDEG = 64'sh0000_0000_0002_bf20;
  // Aux input in millivolts, 1.000 V is unity
  localparam logic [63:0] AUX_UNITY_MV = 64'h0000_0000_0000_03e8;
  localparam logic [1:0] EXP_X1 = 2'h0;
  localparam logic [1:0] EXP_X10 = 2'h1;
  localparam logic [1:0] EXP_X100 = 2'h2;
  localparam logic [1:0] Q_X = 2'h0;
  localparam logic [1:0] Q_Y = 2'h1;
  localparam logic [1:0] Q_R = 2'h2;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SENS = 8'h04;
  localparam logic [7:0] A_CMD = 8'h08;
  localparam logic [7:0] A_KNOB = 8'h0c;
  localparam logic [7:0] A_OFS_X = 8'h10;
  localparam logic [7:0] A_OFS_Y = 8'h14;
  localparam logic [7:0] A_OFS_R = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1c;
  localparam logic [7:0] A_PRESET = 8'h20;
  localparam logic [7:0] A_CURFREQ = 8'h30;
  localparam int B_SEL_R = 0;
  localparam int B_SEL_PH = 1;
  localparam int B_OFF_TGL = 0;
  localparam int B_EXP_CYC = 2;
  localparam int B_AUTO = 4;
  localparam int B_RAT_CYC = 6;
  localparam int B_P_LOAD = 8;
  localparam int B_P_STORE = 12;
  localparam int B_KNOB_CH = 16;
  localparam int B_OFS_ON = 20;
  localparam int B_OFS_EXP = 21;
  localparam int B_OFS_RAT = 23;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic signed [15:0] out_code;
    logic signed [31:0] numeric;
    logic signed [47:0] chart;
    logic scale_warn;
    logic offset_ind;
    logic ratio_ind;
    logic expand_ind;
  } scaled_t;
  typedef enum logic [4:0] {
    ST_LOAD = 5'b00001,
    ST_DIV = 5'b00010,
    ST_OFS = 5'b00100,
    ST_RATIO = 5'b01000,
    ST_OUT = 5'b10000
  } seq_t;
endpackage

// [core/output_scaling_datapath.sv]
/*
  Output scaling datapath: sensitivity, offset, ratio and expand for X, Y, R,
  phase scaling, channel routing, indicators, noise and frequency presets.
  Assumes an AXI4-Lite master on MCLK_I and inputs already on that clock.
*/
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
// Function
// - Value equal to sensitivity yields full-scale ten volt code.
// - Overloaded output, bar and numeric are pinned and scale warning raised.
// - Chart values are never clamped by output overload.
// - Phase on second channel scales 180 degrees to ten volts, no adjustments.
// - Rear outputs carry X and Y; channel one X or R, two Y or phase.
// - Output equals (value/sens minus offset)/(aux/1V) times expand times 10V.
// - Signed offsets up to 999 percent subtracted before expand.
// - Expand of one, ten or hundred; indicator lit when not unity.
// - Ratio divides by aux voltage with one volt as unity.
// - Beyond ten volts sets overload flag, LED and scale warning.
// - X, Y, R each own offset, expand, ratio; phase unaffected.
// - Offsets show in numeric, bar and chart with offset indicator.
// - Ratio normalises numeric, bar and chart with ratio indicator.
// - Expand adds numeric resolution, scales bar, leaves chart unexpanded.
// - Channel source choice decides which settings expand and offset change.
// - Offset toggle keeps percentage; offset LED on while applied.
// - Knob rotation updates stored percentage even when toggled off, except on channel two while it shows phase.
// - Auto offset sets percentage making the corrected value zero.
// - Sensitivity changes leave stored offset percentage untouched.
// - Ratio command cycles off and aux; ratio LED lit when applied.
// - Noise uses scaled values; pinned values yield zero noise.
// - Four presets; touch loads immediately, touch-and-hold stores frequency.
`timescale 1ns/1ps
module output_scaling_datapath #(
  parameter int DIV_STEPS = scaling_pkg::DIV_STEPS_DEF
) (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic signed [31:0] X_I,
  input wire logic signed [31:0] Y_I,
  input wire logic signed [31:0] R_I,
  input wire logic signed [31:0] PHASE_I,
  input wire logic signed [15:0] AUX_I,
  input wire logic [31:0] CUR_FREQ_I,
  input wire logic [7:0] AXI_AWADDR_I,
  input wire logic AXI_AWVALID_I,
  output logic AXI_AWREADY_O,
  input wire logic [31:0] AXI_WDATA_I,
  input wire logic [3:0] AXI_WSTRB_I,
  input wire logic AXI_WVALID_I,
  output logic AXI_WREADY_O,
  output logic [1:0] AXI_BRESP_O,
  output logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  input wire logic [7:0] AXI_ARADDR_I,
  input wire logic AXI_ARVALID_I,
  output logic AXI_ARREADY_O,
  output logic [31:0] AXI_RDATA_O,
  output logic [1:0] AXI_RRESP_O,
  output logic AXI_RVALID_O,
  input wire logic AXI_RREADY_I,
  output scaling_pkg::scaled_t X_RES_O,
  output scaling_pkg::scaled_t Y_RES_O,
  output scaling_pkg::scaled_t R_RES_O,
  output logic signed [15:0] REAR_X_CODE_O,
  output logic signed [15:0] REAR_Y_CODE_O,
  output logic signed [15:0] PRIMARY_CODE_O,
  output logic signed [15:0] SECONDARY_CODE_O,
  output logic OVLD_LED_O,
  output logic [1:0] OFFSET_LED_O,
  output logic [1:0] EXPAND_LED_O,
  output logic [1:0] RATIO_LED_O,
  output logic [31:0] X_NOISE_O,
  output logic [31:0] Y_NOISE_O,
  output logic [31:0] LOAD_FREQ_O,
  output logic LOAD_FREQ_VALID_O
);
  import scaling_pkg::*;

  function automatic logic signed [63:0] sat_f(input logic signed [63:0] v);
    if (v > F_LIMIT) sat_f = F_LIMIT;
    else if (v < -F_LIMIT) sat_f = -F_LIMIT;
    else sat_f = v;
  endfunction

  function automatic logic [63:0] mag(input logic signed [63:0] v);
    mag = v[63] ? 64'(-v) : 64'(v);
  endfunction

  function automatic logic signed [63:0] ofs_frac(input logic signed [17:0] p);
    ofs_frac = (64'(p) * FS_Q) / PCT_SCALE;
  endfunction

  function automatic logic signed [17:0] pct_clip(input logic signed [63:0] v);
    if (v > 64'(PCT_MAX)) pct_clip = PCT_MAX;
    else if (v < -64'(PCT_MAX)) pct_clip = -PCT_MAX;
    else pct_clip = v[17:0];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    for (int b = 0; b < 4; b++) merge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
  endfunction

  // Register bus state
  logic [7:0] awaddr_q;
  logic [31:0] ctrl_m;
  logic [31:0] ofs_m [3];
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire, wr_hit, rd_hit;
  logic [31:0] rd_data;
  // Settings
  logic [1:0] ctrl_q;
  logic [31:0] sens_q;
  logic signed [17:0] pct_q [3];
  logic on_q [3];
  logic [1:0] exp_q [3];
  logic rat_q [3];
  logic signed [63:0] f_last_q [3];
  logic [31:0] preset_q [4];
  logic [1:0] t1, t2;
  logic [31:0] cmd, knob;
  // Sequencer
  seq_t st_q;
  logic [1:0] qi_q;
  logic [63:0] num_q;
  logic [64:0] rem_q;
  logic [31:0] den_q;
  logic [6:0] cnt_q;
  logic neg_q, div2_q;
  logic signed [63:0] d_q;
  logic [64:0] rem_sh;
  logic rem_ge;
  logic signed [63:0] v_in, f_new, d_new, e_new, lim;
  logic ovl_new;
  logic signed [63:0] code_w;
  scaled_t res_q [3];
  logic signed [15:0] phase_code_q;
  logic signed [63:0] ph_prod;

  assign t1 = ctrl_q[B_SEL_R] ? Q_R : Q_X;
  assign t2 = Q_Y;
  assign cmd = wdata_q;
  assign knob = wdata_q;
  assign wr_fire = !AXI_AWREADY_O && !AXI_WREADY_O && !AXI_BVALID_O;

  always_comb begin
    wr_hit = 1'b1;
    case (awaddr_q)
      A_CTRL, A_SENS, A_CMD, A_KNOB, A_OFS_X, A_OFS_Y, A_OFS_R, A_STATUS: wr_hit = 1'b1;
      A_PRESET, A_PRESET + 8'h04, A_PRESET + 8'h08, A_PRESET + 8'h0c, A_CURFREQ: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    rd_data = 32'h0;
    rd_hit = 1'b1;
    case (AXI_ARADDR_I)
      A_CTRL: rd_data = {30'h0, ctrl_q};
      A_SENS: rd_data = sens_q;
      A_CMD, A_KNOB: rd_data = 32'h0;
      A_OFS_X: rd_data = {8'h0, rat_q[0], exp_q[0], on_q[0], 2'h0, pct_q[0]};
      A_OFS_Y: rd_data = {8'h0, rat_q[1], exp_q[1], on_q[1], 2'h0, pct_q[1]};
      A_OFS_R: rd_data = {8'h0, rat_q[2], exp_q[2], on_q[2], 2'h0, pct_q[2]};
      A_STATUS: rd_data = {26'h0, OVLD_LED_O, st_q == ST_LOAD, 1'b0, res_q[2].scale_warn,
                           res_q[1].scale_warn, res_q[0].scale_warn};
      A_PRESET: rd_data = preset_q[0];
      A_PRESET + 8'h04: rd_data = preset_q[1];
      A_PRESET + 8'h08: rd_data = preset_q[2];
      A_PRESET + 8'h0c: rd_data = preset_q[3];
      A_CURFREQ: rd_data = CUR_FREQ_I;
      default: rd_hit = 1'b0;
    endcase
  end
  // Byte-lane merge of written words
  assign ctrl_m = merge({30'h0, ctrl_q}, wdata_q, wstrb_q);
  always_comb begin
    for (int i = 0; i < 3; i++) ofs_m[i] = merge({14'h0, pct_q[i]}, wdata_q, wstrb_q);
  end

  // Write channel: address and data taken in either order
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      AXI_AWREADY_O <= 1'b1;
      AXI_WREADY_O <= 1'b1;
      AXI_BVALID_O <= 1'b0;
      AXI_BRESP_O <= RESP_OKAY;
      awaddr_q <= 8'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (AXI_AWVALID_I && AXI_AWREADY_O) begin
        AXI_AWREADY_O <= 1'b0;
        awaddr_q <= AXI_AWADDR_I;
      end
      if (AXI_WVALID_I && AXI_WREADY_O) begin
        AXI_WREADY_O <= 1'b0;
        wdata_q <= AXI_WDATA_I;
        wstrb_q <= AXI_WSTRB_I;
      end
      if (wr_fire) begin
        AXI_BVALID_O <= 1'b1;
        AXI_BRESP_O <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (AXI_BVALID_O && AXI_BREADY_I) begin
        AXI_BVALID_O <= 1'b0;
        AXI_AWREADY_O <= 1'b1;
        AXI_WREADY_O <= 1'b1;
      end
    end
  end

  // Read channel
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      AXI_ARREADY_O <= 1'b1;
      AXI_RVALID_O <= 1'b0;
      AXI_RDATA_O <= 32'h0;
      AXI_RRESP_O <= RESP_OKAY;
    end else if (AXI_ARVALID_I && AXI_ARREADY_O) begin
      AXI_ARREADY_O <= 1'b0;
      AXI_RVALID_O <= 1'b1;
      AXI_RDATA_O <= rd_data;
      AXI_RRESP_O <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (AXI_RVALID_O && AXI_RREADY_I) begin
      AXI_RVALID_O <= 1'b0;
      AXI_ARREADY_O <= 1'b1;
    end
  end

  // Control and sensitivity
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ctrl_q <= 2'h0;
      sens_q <= 32'h1;
    end else if (wr_fire && awaddr_q == A_CTRL) begin
      ctrl_q <= ctrl_m[1:0];
    end else if (wr_fire && awaddr_q == A_SENS) begin
      sens_q <= merge(sens_q, wdata_q, wstrb_q);
    end
  end

  // Per-quantity offset, expand and ratio settings
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      for (int i = 0; i < 3; i++) begin
        pct_q[i] <= 18'sh0;
        on_q[i] <= 1'b0;
        exp_q[i] <= EXP_X1;
        rat_q[i] <= 1'b0;
      end
    end else if (wr_fire) begin
      for (int i = 0; i < 3; i++) begin
        if (awaddr_q == A_OFS_X + 8'(4 * i)) begin
          pct_q[i] <= pct_clip(64'(signed'(ofs_m[i][17:0])));
          on_q[i] <= wstrb_q[2] ? wdata_q[B_OFS_ON] : on_q[i];
          exp_q[i] <= (wstrb_q[2] && wdata_q[B_OFS_EXP +: 2] <= EXP_X100) ? wdata_q[B_OFS_EXP +: 2] : exp_q[i];
          rat_q[i] <= wstrb_q[2] ? wdata_q[B_OFS_RAT] : rat_q[i];
        end
      end
      if (awaddr_q == A_KNOB) begin
        if (!knob[B_KNOB_CH])
          pct_q[t1] <= pct_clip(64'(pct_q[t1]) + 64'(signed'(knob[15:0])));
        else if (!ctrl_q[B_SEL_PH])
          pct_q[t2] <= pct_clip(64'(pct_q[t2]) + 64'(signed'(knob[15:0])));
      end
      if (awaddr_q == A_CMD) begin
        if (cmd[B_OFF_TGL]) on_q[t1] <= !on_q[t1];
        if (cmd[B_OFF_TGL + 1] && !ctrl_q[B_SEL_PH]) on_q[t2] <= !on_q[t2];
        if (cmd[B_EXP_CYC]) exp_q[t1] <= (exp_q[t1] == EXP_X100) ? EXP_X1 : exp_q[t1] + 2'h1;
        if (cmd[B_EXP_CYC + 1] && !ctrl_q[B_SEL_PH]) exp_q[t2] <= (exp_q[t2] == EXP_X100) ? EXP_X1 : exp_q[t2] + 2'h1;
        if (cmd[B_RAT_CYC]) rat_q[t1] <= !rat_q[t1];
        if (cmd[B_RAT_CYC + 1] && !ctrl_q[B_SEL_PH]) rat_q[t2] <= !rat_q[t2];
        if (cmd[B_AUTO]) begin
          pct_q[t1] <= pct_clip((f_last_q[t1] * PCT_SCALE) >>> FRAC_BITS);
          on_q[t1] <= 1'b1;
        end
        if (cmd[B_AUTO + 1] && !ctrl_q[B_SEL_PH]) begin
          pct_q[t2] <= pct_clip((f_last_q[t2] * PCT_SCALE) >>> FRAC_BITS);
          on_q[t2] <= 1'b1;
        end
      end
    end
  end

  // Frequency presets
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      for (int i = 0; i < 4; i++) preset_q[i] <= 32'h0;
      LOAD_FREQ_O <= 32'h0;
      LOAD_FREQ_VALID_O <= 1'b0;
    end else begin
      LOAD_FREQ_VALID_O <= 1'b0;
      if (wr_fire && awaddr_q == A_CMD) begin
        for (int i = 3; i >= 0; i--) begin
          if (cmd[B_P_STORE + i]) preset_q[i] <= CUR_FREQ_I;
          if (cmd[B_P_LOAD + i]) begin
            LOAD_FREQ_O <= preset_q[i];
            LOAD_FREQ_VALID_O <= 1'b1;
          end
        end
      end else if (wr_fire) begin
        for (int i = 0; i < 4; i++)
          if (awaddr_q == A_PRESET + 8'(4 * i)) preset_q[i] <= merge(preset_q[i], wdata_q, wstrb_q);
      end
    end
  end

  // Shared divider step and scaling arithmetic
  always_comb begin
    rem_sh = {rem_q[63:0], num_q[63]};
    rem_ge = rem_sh >= {33'h0, den_q};
    case (qi_q)
      Q_X: v_in = 64'(X_I);
      Q_Y: v_in = 64'(Y_I);
      default: v_in = 64'(R_I);
    endcase
    f_new = sat_f(neg_q ? -signed'(num_q) : signed'(num_q));
    d_new = on_q[qi_q] ? sat_f(f_new - ofs_frac(pct_q[qi_q])) : f_new;
    case (exp_q[qi_q])
      EXP_X10: begin
        e_new = d_q * 64'sd10;
        lim = FS_Q / 64'sd10;
      end
      EXP_X100: begin
        e_new = d_q * 64'sd100;
        lim = FS_Q / 64'sd100;
      end
      default: begin
        e_new = d_q;
        lim = FS_Q;
      end
    endcase
    ovl_new = (e_new > FS_Q) || (e_new < -FS_Q);
    code_w = e_new >>> CODE_SHIFT;
  end

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      st_q <= ST_LOAD;
      qi_q <= Q_X;
      num_q <= 64'h0;
      rem_q <= 65'h0;
      den_q <= 32'h0;
      cnt_q <= 7'h0;
      neg_q <= 1'b0;
      div2_q <= 1'b0;
      d_q <= 64'sh0;
      for (int i = 0; i < 3; i++) begin
        res_q[i] <= '0;
        f_last_q[i] <= 64'sh0;
      end
      X_NOISE_O <= 32'h0;
      Y_NOISE_O <= 32'h0;
    end else begin
      case (st_q)
        ST_LOAD: begin
          neg_q <= v_in[63];
          num_q <= mag(v_in) << FRAC_BITS;
          rem_q <= 65'h0;
          den_q <= sens_q;
          cnt_q <= 7'h0;
          div2_q <= 1'b0;
          st_q <= ST_DIV;
        end
        ST_DIV: begin
          rem_q <= rem_ge ? rem_sh - {33'h0, den_q} : rem_sh;
          num_q <= {num_q[62:0], rem_ge};
          cnt_q <= cnt_q + 7'h1;
          if (cnt_q == 7'(DIV_STEPS - 1)) st_q <= div2_q ? ST_RATIO : ST_OFS;
        end
        ST_OFS: begin
          f_last_q[qi_q] <= f_new;
          d_q <= d_new;
          if (rat_q[qi_q]) begin
            neg_q <= d_new[63] ^ AUX_I[15];
            num_q <= mag(d_new) * AUX_UNITY_MV;
            rem_q <= 65'h0;
            den_q <= 32'(mag(64'(AUX_I)));
            cnt_q <= 7'h0;
            div2_q <= 1'b1;
            st_q <= ST_DIV;
          end else begin
            st_q <= ST_OUT;
          end
        end
        ST_RATIO: begin
          d_q <= f_new;
          st_q <= ST_OUT;
        end
        ST_OUT: begin
          res_q[qi_q].scale_warn <= ovl_new;
          res_q[qi_q].out_code <= (code_w > 64'(CODE_MAX)) ? CODE_MAX
                                  : (code_w < 64'(CODE_MIN)) ? CODE_MIN : 16'(code_w);
          res_q[qi_q].numeric <= ovl_new ? 32'(e_new[63] ? -lim : lim) : 32'(d_q);
          res_q[qi_q].chart <= 48'(d_q);
          res_q[qi_q].offset_ind <= on_q[qi_q] && pct_q[qi_q] != 18'sh0;
          res_q[qi_q].ratio_ind <= rat_q[qi_q];
          res_q[qi_q].expand_ind <= exp_q[qi_q] != EXP_X1;
          if (qi_q == Q_X)
            X_NOISE_O <= ovl_new ? 32'h0 : 32'(mag(64'(d_q) - 64'(res_q[0].numeric)));
          if (qi_q == Q_Y)
            Y_NOISE_O <= ovl_new ? 32'h0 : 32'(mag(64'(d_q) - 64'(res_q[1].numeric)));
          qi_q <= (qi_q == Q_R) ? Q_X : qi_q + 2'h1;
          st_q <= ST_LOAD;
        end
        default: st_q <= ST_LOAD;
      endcase
    end
  end

  // Phase scaling and output routing
  always_comb begin
    ph_prod = (64'(PHASE_I) * 64'(CODE_MAX)) / PHASE_FS_MDEG;
  end

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      phase_code_q <= 16'sh0;
      REAR_X_CODE_O <= 16'sh0;
      REAR_Y_CODE_O <= 16'sh0;
      PRIMARY_CODE_O <= 16'sh0;
      SECONDARY_CODE_O <= 16'sh0;
      OVLD_LED_O <= 1'b0;
      OFFSET_LED_O <= 2'h0;
      EXPAND_LED_O <= 2'h0;
      RATIO_LED_O <= 2'h0;
    end else begin
      phase_code_q <= (ph_prod > 64'(CODE_MAX)) ? CODE_MAX : (ph_prod < 64'(CODE_MIN)) ? CODE_MIN : 16'(ph_prod);
      REAR_X_CODE_O <= res_q[0].out_code;
      REAR_Y_CODE_O <= res_q[1].out_code;
      PRIMARY_CODE_O <= ctrl_q[B_SEL_R] ? res_q[2].out_code : res_q[0].out_code;
      SECONDARY_CODE_O <= ctrl_q[B_SEL_PH] ? phase_code_q : res_q[1].out_code;
      OVLD_LED_O <= res_q[0].scale_warn || res_q[1].scale_warn || res_q[2].scale_warn;
      OFFSET_LED_O <= {!ctrl_q[B_SEL_PH] && on_q[t2], on_q[t1]};
      EXPAND_LED_O <= {!ctrl_q[B_SEL_PH] && exp_q[t2] != EXP_X1, exp_q[t1] != EXP_X1};
      RATIO_LED_O <= {!ctrl_q[B_SEL_PH] && rat_q[t2], rat_q[t1]};
    end
  end

  assign X_RES_O = res_q[0];
  assign Y_RES_O = res_q[1];
  assign R_RES_O = res_q[2];

  // Checks
  sequence s_div_start;
    st_q == ST_LOAD;
  endsequence
  sequence s_div_end;
    st_q == ST_OFS;
  endsequence
  property p_div_bound;
    @(posedge MCLK_I) disable iff (RESET_I) s_div_start |=> ##[1:70] s_div_end;
  endproperty
  a_div_bound: assert property (p_div_bound) else $error("division overran");
  property p_pinned;
    @(posedge MCLK_I) disable iff (RESET_I)
      res_q[0].scale_warn |-> (res_q[0].out_code == CODE_MAX || res_q[0].out_code == CODE_MIN);
  endproperty
  a_pinned: assert property (p_pinned) else $error("overloaded code not pinned");
  property p_symmetric;
    @(posedge MCLK_I) disable iff (RESET_I) PRIMARY_CODE_O != -16'sh8000 && SECONDARY_CODE_O != -16'sh8000;
  endproperty
  a_symmetric: assert property (p_symmetric) else $error("code beyond negative full scale");
  property p_phase_route;
    @(posedge MCLK_I) disable iff (RESET_I) ctrl_q[B_SEL_PH] |=> SECONDARY_CODE_O == $past(phase_code_q);
  endproperty
  a_phase_route: assert property (p_phase_route) else $error("phase not routed");
  property p_primary_route;
    @(posedge MCLK_I) disable iff (RESET_I)
      ##1 PRIMARY_CODE_O == ($past(ctrl_q[B_SEL_R]) ? $past(res_q[2].out_code) : $past(res_q[0].out_code));
  endproperty
  a_primary_route: assert property (p_primary_route) else $error("channel one source wrong");
  property p_ovld_led;
    @(posedge MCLK_I) disable iff (RESET_I) (res_q[0].scale_warn || res_q[1].scale_warn) |=> OVLD_LED_O;
  endproperty
  a_ovld_led: assert property (p_ovld_led) else $error("overload LED missing");
  property p_toggle;
    @(posedge MCLK_I) disable iff (RESET_I)
      (wr_fire && awaddr_q == A_CMD && cmd[B_OFF_TGL] && !cmd[B_AUTO])
      |=> on_q[$past(t1)] != $past(on_q[t1]) && pct_q[$past(t1)] == $past(pct_q[t1]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("offset toggle misbehaved");
  property p_sens_keep;
    @(posedge MCLK_I) disable iff (RESET_I) (wr_fire && awaddr_q == A_SENS) |=> pct_q[0] == $past(pct_q[0]);
  endproperty
  a_sens_keep: assert property (p_sens_keep) else $error("sensitivity changed offset");
  property p_noise_zero;
    @(posedge MCLK_I) disable iff (RESET_I) (st_q == ST_OUT && qi_q == Q_X && ovl_new) |=> X_NOISE_O == 32'h0;
  endproperty
  a_noise_zero: assert property (p_noise_zero) else $error("pinned value gave noise");
  property p_preset_load;
    @(posedge MCLK_I) disable iff (RESET_I)
      (wr_fire && awaddr_q == A_CMD && cmd[B_P_LOAD]) |=> LOAD_FREQ_VALID_O ##1 !LOAD_FREQ_VALID_O;
  endproperty
  a_preset_load: assert property (p_preset_load) else $error("preset load not pulsed");
endmodule // output_scaling_datapath

// [dv/output_scaling_datapath_test.sv]
/*
  Self-checking bench for the output scaling datapath.
  Assumes scaling_pkg compiled first; drives AXI4-Lite and sample inputs itself.
*/
`timescale 1ns/1ps
module output_scaling_datapath_test;
  import scaling_pkg::*;
  logic mclk, rst, awv, wv, bready, arv, rready, awr, wrdy, bv, arr, rv, ovld, lfv;
  logic signed [31:0] x_in, y_in, r_in, ph_in;
  logic signed [15:0] aux_in, rear_x, rear_y, prim, sec;
  logic [31:0] cur_freq, wdata, rdata, freq_o, rd_v, xn, yn;
  logic [7:0] awaddr, araddr;
  logic [1:0] bresp, rresp, rd_r, ofs_led, exp_led, rat_led;
  scaled_t xr, yr, rr;
  int miscompares, checks, pulses;
  longint xv, yv;
  output_scaling_datapath DUT (.MCLK_I(mclk), .RESET_I(rst), .X_I(x_in), .Y_I(y_in), .R_I(r_in),
    .PHASE_I(ph_in), .AUX_I(aux_in), .CUR_FREQ_I(cur_freq), .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awv),
    .AXI_AWREADY_O(awr), .AXI_WDATA_I(wdata), .AXI_WSTRB_I(4'hf), .AXI_WVALID_I(wv), .AXI_WREADY_O(wrdy),
    .AXI_BRESP_O(bresp), .AXI_BVALID_O(bv), .AXI_BREADY_I(bready), .AXI_ARADDR_I(araddr),
    .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr), .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp),
    .AXI_RVALID_O(rv), .AXI_RREADY_I(rready), .X_RES_O(xr), .Y_RES_O(yr), .R_RES_O(rr),
    .REAR_X_CODE_O(rear_x), .REAR_Y_CODE_O(rear_y), .PRIMARY_CODE_O(prim), .SECONDARY_CODE_O(sec),
    .OVLD_LED_O(ovld), .OFFSET_LED_O(ofs_led), .EXPAND_LED_O(exp_led), .RATIO_LED_O(rat_led),
    .X_NOISE_O(xn), .Y_NOISE_O(yn), .LOAD_FREQ_O(freq_o), .LOAD_FREQ_VALID_O(lfv));
  initial begin
    mclk = 0;
    forever #12.5 mclk = ~mclk;
  end
  always @(negedge mclk) if (lfv === 1'b1) pulses <= pulses + 1;
  task report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #(25 * 60000);
    miscompares++;
    report_and_stop;
  end
  task chk(input string n, input longint e, input logic [63:0] g);
    checks++;
    if (g !== 64'(e)) begin
      miscompares++;
      $display("BAD %s expected %0d seen %0d", n, e, $signed(g));
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    awaddr <= a; wdata <= d; awv <= 1; wv <= 1; tb = 0;
    while (!tb) begin
      @(negedge mclk); ta = awr; tw = wrdy; tb = bv;
      @(posedge mclk); if (ta) awv <= 0; if (tw) wv <= 0;
    end
  endtask
  task automatic axr(input logic [7:0] a);
    logic tr, td;
    araddr <= a; arv <= 1; td = 0;
    while (!td) begin
      @(negedge mclk); tr = arr; td = rv; rd_v = rdata; rd_r = rresp;
      @(posedge mclk); if (tr) arv <= 0;
    end
  endtask
  task settle;
    repeat (1000) @(posedge mclk);
  endtask
  initial begin
    x_in = 0; y_in = 0; r_in = 0; ph_in = 0; aux_in = 16'sd1000; cur_freq = 0; wdata = 0;
    awaddr = 0; araddr = 0; awv = 0; wv = 0; bready = 1; arv = 0; rready = 1; rst = 1;
    void'($urandom(14149));
    repeat (6) @(posedge mclk);
    rst <= 0;
    axr(A_SENS); chk("sens_reset", 1, rd_v);
    axr(A_OFS_X); chk("ofs_reset", 0, rd_v);
    axr(8'h44); chk("unmapped_resp", 2, rd_r); chk("unmapped_data", 0, rd_v);
    axw(A_SENS, 1024); r_in <= 256;
    for (int i = 0; i < 3; i++) begin
      xv = $urandom_range(1023); yv = -longint'($urandom_range(1023));
      x_in <= 32'(xv); y_in <= 32'(yv); settle;
      chk("x_code", xv * 32, 64'(xr.out_code));
      chk("x_num", xv * 4096, 64'(xr.numeric));
      chk("rear_x", xv * 32, 64'(rear_x));
      chk("rear_y", yv * 32, 64'(rear_y));
      chk("prim", xv * 32, 64'(prim));
      chk("sec", yv * 32, 64'(sec));
    end
    axw(A_CTRL, 3); ph_in <= 90000; x_in <= 1024; axw(A_CMD, 8); settle;
    chk("prim_r", 8192, 64'(prim));
    chk("sec_phase", 16383, 64'(sec));
    chk("x_fs", 32767, 64'(xr.out_code));
    chk("x_fs_warn", 0, 64'(xr.scale_warn));
    chk("ph_no_exp", 0, 64'(exp_led[1]));
    axr(A_OFS_Y); chk("ph_y_keep", 0, rd_v);
    axw(A_CTRL, 0); x_in <= 2048; settle;
    chk("x_pin", 32767, 64'(xr.out_code));
    chk("x_num_pin", 4194304, 64'(xr.numeric));
    chk("x_warn", 1, 64'(xr.scale_warn));
    chk("ovld_led", 1, 64'(ovld));
    chk("x_chart", 8388608, 64'(xr.chart));
    chk("x_noise_pin", 0, 64'(xn));
    chk("y_noise", 0, 64'(yn));
    x_in <= -2048; settle;
    chk("x_neg_pin", -32767, 64'(xr.out_code));
    x_in <= 512; axw(A_OFS_X, 32'h0010_1388); settle;
    chk("x_num_ofs", 0, 64'(xr.numeric));
    chk("x_chart_ofs", 0, 64'(xr.chart));
    chk("ofs_ind", 1, 64'(xr.offset_ind));
    chk("ofs_led", 1, 64'(ofs_led[0]));
    axw(A_SENS, 2048); axr(A_OFS_X); chk("ofs_keep", 32'h0010_1388, rd_v);
    axw(A_SENS, 1024); axw(A_CMD, 1); axr(A_OFS_X); chk("ofs_tgl", 32'h1388, rd_v);
    settle; chk("x_num_tgl", 2097152, 64'(xr.numeric));
    axw(A_KNOB, 100); axr(A_OFS_X); chk("knob", 32'h13ec, rd_v);
    axw(A_CMD, 32'h10); settle; chk("auto_ofs", 0, 64'(xr.numeric));
    x_in <= 64; axw(A_OFS_X, 32'h0020_0000); settle;
    chk("x_exp_code", 20480, 64'(xr.out_code));
    chk("x_exp_num", 262144, 64'(xr.numeric));
    chk("exp_led", 1, 64'(exp_led[0]));
    axw(A_OFS_X, 32'h0040_0000); settle;
    chk("x_exp100", 32767, 64'(xr.out_code));
    chk("x_exp_chart", 262144, 64'(xr.chart));
    aux_in <= 2000; axw(A_OFS_X, 32'h0080_0000); settle;
    chk("x_ratio", 131072, 64'(xr.numeric));
    chk("rat_ind", 1, 64'(xr.ratio_ind));
    chk("rat_led", 1, 64'(rat_led[0]));
    chk("r_free", 1048576, 64'(rr.numeric));
    axw(A_CMD, 32'h40); axr(A_OFS_X); chk("rat_cyc", 0, rd_v);
    axw(A_CTRL, 1); axw(A_CMD, 4); axr(A_OFS_R); chk("sel_r", 32'h0020_0000, rd_v);
    axr(A_OFS_X); chk("sel_x", 0, rd_v);
    axw(A_PRESET, 123); axw(A_CMD, 32'h100);
    chk("load_freq", 123, freq_o);
    chk("load_pulse", 1, pulses);
    cur_freq <= 777; axw(A_CMD, 32'h2000); axr(8'h24); chk("store", 777, rd_v);
    report_and_stop;
  end
endmodule // output_scaling_datapath_test
